// [design/wsc_regs.sv]
// Purpose: Wake source control register bank with reset, restart and fail-safe loads
// Assumes: Register port is synchronous to core_clk_i; one access per cycle
// Notes: Reads answer one cycle after the request; reserved bits read zero
`timescale 1ns/1ps
`include "wsc_defines.svh"

// Operation
// - Bus control two bit 5 picks low (0) or high (1) peak threshold.
// - Peak threshold bit is writable only in init or normal state.
// - In stop state peak writes are dropped, no error, no interrupt.
// - Fail-safe entry forces external wake register to x0x0 0111.
// - Internal wake bits 7 and 6 enable timer two and timer one wake.
// - Internal wake bit 2 disables watchdog in stop; hardware may set it.
// - External bit 7: 0 only wake interrupts, 1 all status events.
// - External bit 5 set makes inputs one and two ignore wake enables.
// - Measurement select offers measurement in normal state instead of wake.
// - External bits 2..0 enable wake inputs three, two, one.
// - Reserved bits read zero and ignore writes.
// - Reset loads external 0000 0111, the other three all zeros.
// - Restart keeps external bits 7,5,2,1,0 and clears 6,4,3.
// - Restart keeps internal bits 7 and 6, clears the rest.
// - Restart keeps bus control two bit 5, clears the rest.
// - Restart keeps pull bits 5..0 and clears bits 7 and 6.
// - Pull codes: 00 none, 01 down, 10 up, 11 automatic.
// - Transceiver codes 001 and 101 count as bus wake capable.
module wsc_regs
   import wsc_pkg::*;
(
   input wire logic core_clk_i, // 250 MHz clock
   input wire logic sys_rst_i, // Power-on reset, sync, high
   input wire logic soft_rst_i, // Soft reset pulse
   input wire logic restart_i, // Restart entry pulse
   input wire logic failsafe_i, // Fail-safe entry pulse
   input wire logic [1:0] mode_i, // Operating state, wsc_mode_t
   input wire logic wr_en_i, // Register write strobe
   input wire logic rd_en_i, // Register read strobe
   input wire logic [6:0] addr_i, // Register address
   input wire logic [7:0] wdata_i, // Write data
   input wire logic hw_wd_upd_i, // Hardware update of watchdog stop bit
   input wire logic hw_wd_val_i, // Value for that update
   input wire logic [2:0] can_mode_i, // Transceiver mode field
   input wire logic wake_event_i, // Wake event pulse
   input wire logic status_event_i, // Other status event pulse
   output logic [7:0] rdata_o, // Read data
   output logic rd_valid_o, // Read answer pulse
   output logic access_err_o, // Unmapped access pulse
   output logic peak_current_threshold_sel_o, // High peak threshold
   output logic watchdog_stop_disable_b1_o, // Watchdog off in stop
   output logic int_scope_all_o, // All status bits interrupt
   output logic measure_mode_select_o, // Inputs one, two for measurement
   output logic [2:0] wake_en_o, // Effective wake enables three..one
   output logic [1:0] timer_wake_o, // Timer two, one wake enables
   output logic meas_active_o, // Measurement function available
   output logic can_wake_o, // Bus wake source active
   output logic [2:0] pull_up_o, // Pull-up per input
   output logic [2:0] pull_down_o, // Pull-down per input
   output logic [2:0] pull_auto_o, // Automatic pull per input
   output logic int_req_o // Interrupt request pulse
);
   // Merge written bits into the old image, reserved bits stay zero
   function automatic logic [7:0] wr_merge(input logic [7:0] old, input logic [7:0] data,
      input logic [7:0] mask);
      wr_merge = (old & ~mask) | (data & mask);
   endfunction

   // Restart load: keep x bits, force the rest to zero
   function automatic logic [7:0] keep_only(input logic [7:0] old, input logic [7:0] keep);
      keep_only = old & keep;
   endfunction

   logic [7:0] bus_two_q, bus_two_d;
   logic [7:0] int_wake_q, int_wake_d;
   logic [7:0] ext_wake_q, ext_wake_d;
   logic [7:0] pull_q, pull_d;
   logic [7:0] rdata_d;

   wsc_cfg_if cfg ();

   // Mode and address decode
   wire logic mode_init = (mode_i == WSC_MODE_INIT);
   wire logic mode_normal = (mode_i == WSC_MODE_NORMAL);
   wire logic mode_stop = (mode_i == WSC_MODE_STOP);
   wire logic hit_bus_two = (addr_i == `WSC_OFF_BUS_TWO);
   wire logic hit_int_wake = (addr_i == `WSC_OFF_INT_WAKE);
   wire logic hit_ext_wake = (addr_i == `WSC_OFF_EXT_WAKE);
   wire logic hit_pull = (addr_i == `WSC_OFF_PULL);
   wire logic hit_any = hit_bus_two | hit_int_wake | hit_ext_wake | hit_pull;
   wire logic reload = sys_rst_i | soft_rst_i;

   // Write qualifiers; peak bit only in init or normal, stop drops silently
   wire logic peak_wr_ok = mode_init | mode_normal;
   wire logic wr_bus_two = wr_en_i & hit_bus_two & peak_wr_ok;
   wire logic wr_int_wake = wr_en_i & hit_int_wake;
   wire logic wr_ext_wake = wr_en_i & hit_ext_wake;
   wire logic wr_pull = wr_en_i & hit_pull;
   // A stop-state peak write is a legal address, so it never flags an error
   wire logic err_d = (wr_en_i | rd_en_i) & ~hit_any;

   // Bus control two next value
   always_comb begin
      bus_two_d = bus_two_q;
      if (soft_rst_i) begin
         bus_two_d = `WSC_RST_BUS_TWO;
      end else if (failsafe_i) begin
         // Forced value passes the mask, so reserved bit 0 stays zero
         bus_two_d = `WSC_FS_BUS_TWO & `WSC_MASK_BUS_TWO;
      end else if (restart_i) begin
         bus_two_d = keep_only(bus_two_q, `WSC_KEEP_BUS_TWO);
      end else if (wr_bus_two) begin
         bus_two_d = wr_merge(bus_two_q, wdata_i, `WSC_MASK_BUS_TWO);
      end
   end

   // Internal wake next value; hardware update beats a software write
   always_comb begin
      int_wake_d = int_wake_q;
      if (soft_rst_i) begin
         int_wake_d = `WSC_RST_INT_WAKE;
      end else if (restart_i) begin
         int_wake_d = keep_only(int_wake_q, `WSC_KEEP_INT_WAKE);
      end else begin
         if (wr_int_wake) begin
            int_wake_d = wr_merge(int_wake_q, wdata_i, `WSC_MASK_INT_WAKE);
         end
         if (hw_wd_upd_i) begin
            int_wake_d[`WSC_BIT_WD_STOP] = hw_wd_val_i;
         end
      end
   end

   // External wake next value; fail-safe sets all three wake enable bits, keeps bits 7 and 5
   always_comb begin
      ext_wake_d = ext_wake_q;
      if (soft_rst_i) begin
         ext_wake_d = `WSC_RST_EXT_WAKE;
      end else if (failsafe_i) begin
         ext_wake_d = (ext_wake_q & `WSC_FS_KEEP_EXT) | `WSC_FS_SET_EXT;
      end else if (restart_i) begin
         ext_wake_d = keep_only(ext_wake_q, `WSC_KEEP_EXT_WAKE);
      end else if (wr_ext_wake) begin
         ext_wake_d = wr_merge(ext_wake_q, wdata_i, `WSC_MASK_EXT_WAKE);
      end
   end

   // Pull configuration next value
   always_comb begin
      pull_d = pull_q;
      if (soft_rst_i) begin
         pull_d = `WSC_RST_PULL;
      end else if (restart_i) begin
         pull_d = keep_only(pull_q, `WSC_KEEP_PULL);
      end else if (wr_pull) begin
         pull_d = wr_merge(pull_q, wdata_i, `WSC_MASK_PULL);
      end
   end

   // Read mux; unmapped addresses read zero
   always_comb begin
      rdata_d = 8'h00;
      if (hit_bus_two) begin
         rdata_d = bus_two_q;
      end else if (hit_int_wake) begin
         rdata_d = int_wake_q;
      end else if (hit_ext_wake) begin
         rdata_d = ext_wake_q;
      end else if (hit_pull) begin
         rdata_d = pull_q;
      end
   end

   // Register images
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         bus_two_q <= `WSC_RST_BUS_TWO;
         int_wake_q <= `WSC_RST_INT_WAKE;
         ext_wake_q <= `WSC_RST_EXT_WAKE;
         pull_q <= `WSC_RST_PULL;
      end else begin
         bus_two_q <= bus_two_d;
         int_wake_q <= int_wake_d;
         ext_wake_q <= ext_wake_d;
         pull_q <= pull_d;
      end
   end

   // Read answer and error pulse
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         rdata_o <= 8'h00;
         rd_valid_o <= 1'b0;
         access_err_o <= 1'b0;
      end else begin
         if (rd_en_i) begin
            rdata_o <= rdata_d;
         end
         rd_valid_o <= rd_en_i;
         access_err_o <= err_d;
      end
   end

   // Field outputs, registered one cycle behind the images
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         peak_current_threshold_sel_o <= 1'b0;
         watchdog_stop_disable_b1_o <= 1'b0;
         int_scope_all_o <= 1'b0;
         measure_mode_select_o <= 1'b0;
      end else begin
         peak_current_threshold_sel_o <= bus_two_q[`WSC_BIT_PEAK_SEL];
         watchdog_stop_disable_b1_o <= int_wake_q[`WSC_BIT_WD_STOP];
         int_scope_all_o <= ext_wake_q[`WSC_BIT_INT_SCOPE];
         measure_mode_select_o <= ext_wake_q[`WSC_BIT_MEAS_SEL];
      end
   end

   // Images to the helpers
   assign cfg.bus_two = bus_two_q;
   assign cfg.int_wake = int_wake_q;
   assign cfg.ext_wake = ext_wake_q;
   assign cfg.pull = pull_q;
   assign cfg.normal_mode = mode_normal;

   // Effective wake enables, pull selections and bus wake flag
   wsc_wake_decode u_decode (
      .core_clk_i(core_clk_i),
      .sys_rst_i(sys_rst_i),
      .cfg(cfg),
      .can_mode_i(can_mode_i), // Transceiver code, decoded below
      .wake_en_o(wake_en_o),
      .timer_wake_o(timer_wake_o),
      .meas_active_o(meas_active_o),
      .can_wake_o(can_wake_o),
      .pull_up_o(pull_up_o),
      .pull_down_o(pull_down_o),
      .pull_auto_o(pull_auto_o)
   );

   // Dropped stop-state writes never reach this gate as events
   wsc_int_gate u_int (
      .core_clk_i(core_clk_i),
      .sys_rst_i(sys_rst_i),
      .cfg(cfg),
      .wake_event_i(wake_event_i),
      .status_event_i(status_event_i),
      .int_req_o(int_req_o)
   );

   wire logic quiet = !soft_rst_i && !failsafe_i && !restart_i;

   property p_stop_drop;
      @(posedge core_clk_i) disable iff (sys_rst_i)
      (wr_en_i && hit_bus_two && mode_stop && quiet) |=> (bus_two_q == $past(bus_two_q));
   endproperty
   a_stop_drop: assert property (p_stop_drop) else $error("stop write took effect");

   property p_stop_no_err;
      @(posedge core_clk_i) disable iff (sys_rst_i)
      (wr_en_i && hit_bus_two && mode_stop) |=> !access_err_o;
   endproperty
   a_stop_no_err: assert property (p_stop_no_err) else $error("stop write flagged");

   property p_peak_write;
      @(posedge core_clk_i) disable iff (sys_rst_i)
      (wr_en_i && hit_bus_two && (mode_init || mode_normal) && quiet)
         |=> ##1 (peak_current_threshold_sel_o == $past(wdata_i[`WSC_BIT_PEAK_SEL], 2));
   endproperty
   a_peak_write: assert property (p_peak_write) else $error("peak bit not written");

   property p_reserved;
      @(posedge core_clk_i) disable iff (sys_rst_i)
      ((bus_two_q & ~`WSC_MASK_BUS_TWO) == 8'h00) && ((int_wake_q & ~`WSC_MASK_INT_WAKE) == 8'h00)
         && ((ext_wake_q & ~`WSC_MASK_EXT_WAKE) == 8'h00) && ((pull_q & ~`WSC_MASK_PULL) == 8'h00);
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bit set");

   property p_failsafe;
      @(posedge core_clk_i) disable iff (sys_rst_i)
      (failsafe_i && !soft_rst_i)
         |=> (ext_wake_q == (($past(ext_wake_q) & 8'hA0) | 8'h07)) ##1 (wake_en_o[2] == 1'b1);
   endproperty
   a_failsafe: assert property (p_failsafe) else $error("fail-safe load wrong");

   property p_restart_ext;
      @(posedge core_clk_i) disable iff (sys_rst_i)
      (restart_i && !soft_rst_i && !failsafe_i) |=> (ext_wake_q == ($past(ext_wake_q) & 8'hA7));
   endproperty
   a_restart_ext: assert property (p_restart_ext) else $error("restart external wrong");

   property p_restart_int;
      @(posedge core_clk_i) disable iff (sys_rst_i)
      (restart_i && !soft_rst_i) |=> (int_wake_q == ($past(int_wake_q) & 8'hC0));
   endproperty
   a_restart_int: assert property (p_restart_int) else $error("restart internal wrong");

   property p_restart_bus;
      @(posedge core_clk_i) disable iff (sys_rst_i)
      (restart_i && quiet == 1'b0 && !soft_rst_i && !failsafe_i)
         |=> (bus_two_q == ($past(bus_two_q) & 8'h20));
   endproperty
   a_restart_bus: assert property (p_restart_bus) else $error("restart bus two wrong");

   property p_restart_pull;
      @(posedge core_clk_i) disable iff (sys_rst_i)
      (restart_i && !soft_rst_i) |=> (pull_q == ($past(pull_q) & 8'h3F));
   endproperty
   a_restart_pull: assert property (p_restart_pull) else $error("restart pull wrong");

   property p_soft_reset;
      @(posedge core_clk_i) disable iff (sys_rst_i)
      soft_rst_i |=> (ext_wake_q == 8'h07) && (bus_two_q == 8'h00) && (int_wake_q == 8'h00)
         && (pull_q == 8'h00);
   endproperty
   a_soft_reset: assert property (p_soft_reset) else $error("soft reset values wrong");

   property p_hw_wd;
      @(posedge core_clk_i) disable iff (sys_rst_i)
      (hw_wd_upd_i && !soft_rst_i && !restart_i)
         |=> ##1 (watchdog_stop_disable_b1_o == $past(hw_wd_val_i, 2));
   endproperty
   a_hw_wd: assert property (p_hw_wd) else $error("hardware watchdog update lost");

   property p_meas_normal;
      @(posedge core_clk_i) disable iff (sys_rst_i)
      (ext_wake_q[`WSC_BIT_MEAS_SEL] && mode_normal) |=> meas_active_o;
   endproperty
   a_meas_normal: assert property (p_meas_normal) else $error("measurement not offered");

   property p_read;
      @(posedge core_clk_i) disable iff (sys_rst_i)
      (rd_en_i && hit_ext_wake) |=> rd_valid_o && (rdata_o == $past(ext_wake_q));
   endproperty
   a_read: assert property (p_read) else $error("read data wrong");
endmodule // wsc_regs

// [common/wsc_defines.svh]
// Purpose: Offsets, field positions, reset, restart and fail-safe values of the wake bank
// Assumes: 7-bit register address, 8-bit register data
// Notes: Definitions only
`ifndef WSC_DEFINES_SVH
`define WSC_DEFINES_SVH

// Register offsets
`define WSC_OFF_BUS_TWO 7'h05
`define WSC_OFF_INT_WAKE 7'h06
`define WSC_OFF_EXT_WAKE 7'h07
`define WSC_OFF_PULL 7'h08

// Field positions
`define WSC_BIT_PEAK_SEL 5
`define WSC_BIT_TMR_TWO 7
`define WSC_BIT_TMR_ONE 6
`define WSC_BIT_WD_STOP 2
`define WSC_BIT_INT_SCOPE 7
`define WSC_BIT_MEAS_SEL 5
`define WSC_BIT_WAKE_THREE 2
`define WSC_BIT_WAKE_TWO 1
`define WSC_BIT_WAKE_ONE 0

// Implemented bits; the rest are reserved, read zero, ignore writes
`define WSC_MASK_BUS_TWO 8'h20
`define WSC_MASK_INT_WAKE 8'hC4
`define WSC_MASK_EXT_WAKE 8'hA7
`define WSC_MASK_PULL 8'h3F

// Power-on and soft reset values
`define WSC_RST_BUS_TWO 8'h00
`define WSC_RST_INT_WAKE 8'h00
`define WSC_RST_EXT_WAKE 8'h07
`define WSC_RST_PULL 8'h00

// Restart: bits kept (x); all other bits forced to zero
`define WSC_KEEP_BUS_TWO 8'h20
`define WSC_KEEP_INT_WAKE 8'hC0
`define WSC_KEEP_EXT_WAKE 8'hA7
`define WSC_KEEP_PULL 8'h3F

// Fail-safe entry: kept bits and forced ones
`define WSC_FS_KEEP_EXT 8'hA0
`define WSC_FS_SET_EXT 8'h07
`define WSC_FS_BUS_TWO 8'h01

// Pull field codes
`define WSC_PULL_NONE 2'b00
`define WSC_PULL_DOWN 2'b01
`define WSC_PULL_UP 2'b10
`define WSC_PULL_AUTO 2'b11

// Transceiver codes that make the bus a wake source
`define WSC_CAN_WAKE_PLAIN 3'b001
`define WSC_CAN_WAKE_SEL 3'b101

`endif

// [common/wsc_pkg.sv]
// Purpose: Types shared by the wake source control bank
// Assumes: Constants live in wsc_defines.svh
// Notes: Types only
package wsc_pkg;
   // Chip operating state as seen by the bank
   typedef enum logic [1:0] {
      WSC_MODE_INIT,
      WSC_MODE_NORMAL,
      WSC_MODE_STOP,
      WSC_MODE_OTHER
   } wsc_mode_t;
endpackage

// [common/wsc_cfg_if.sv]
// Purpose: Carries the four register images from the bank to its helpers
// Assumes: One clock domain
// Notes: Reserved bits are already zero on these wires
`timescale 1ns/1ps
interface wsc_cfg_if;
   logic [7:0] bus_two;
   logic [7:0] int_wake;
   logic [7:0] ext_wake;
   logic [7:0] pull;
   logic normal_mode;
   modport src (output bus_two, output int_wake, output ext_wake, output pull,
      output normal_mode);
   modport dst (input bus_two, input int_wake, input ext_wake, input pull,
      input normal_mode);
endinterface

// [design/wsc_wake_decode.sv]
// Purpose: Turns the register images into effective wake enables and pull selections
// Assumes: Registered outputs, one cycle behind the registers
// Notes: Measurement use of inputs one and two masks their wake enables
`timescale 1ns/1ps
`include "wsc_defines.svh"
module wsc_wake_decode
   import wsc_pkg::*;
(
   input wire logic core_clk_i, // 250 MHz clock
   input wire logic sys_rst_i, // Sync reset, high
   wsc_cfg_if.dst cfg, // Register images
   input wire logic [2:0] can_mode_i, // Transceiver mode field
   output logic [2:0] wake_en_o, // Effective wake enables 3..1
   output logic [1:0] timer_wake_o, // Timer two, timer one wake
   output logic meas_active_o, // Measurement available
   output logic can_wake_o, // Bus counts as wake source
   output logic [2:0] pull_up_o, // Pull-up per input
   output logic [2:0] pull_down_o, // Pull-down per input
   output logic [2:0] pull_auto_o // Automatic pull per input
);
   // Decode one two-bit pull field into up, down, auto
   function automatic logic [2:0] pull_dec(input logic [1:0] code);
      pull_dec = {code == `WSC_PULL_AUTO, code == `WSC_PULL_DOWN, code == `WSC_PULL_UP};
   endfunction

   wire logic meas_sel = cfg.ext_wake[`WSC_BIT_MEAS_SEL];
   wire logic [2:0] wake_d = {cfg.ext_wake[`WSC_BIT_WAKE_THREE],
      cfg.ext_wake[`WSC_BIT_WAKE_TWO] & ~meas_sel,
      cfg.ext_wake[`WSC_BIT_WAKE_ONE] & ~meas_sel};
   wire logic [2:0] p1 = pull_dec(cfg.pull[1:0]);
   wire logic [2:0] p2 = pull_dec(cfg.pull[3:2]);
   wire logic [2:0] p3 = pull_dec(cfg.pull[5:4]);
   wire logic can_d = (can_mode_i == `WSC_CAN_WAKE_PLAIN) ||
      (can_mode_i == `WSC_CAN_WAKE_SEL);

   // Register everything so top outputs come from flops
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         wake_en_o <= 3'h7;
         timer_wake_o <= 2'h0;
         meas_active_o <= 1'b0;
         can_wake_o <= 1'b0;
         pull_up_o <= 3'h0;
         pull_down_o <= 3'h0;
         pull_auto_o <= 3'h0;
      end else begin
         wake_en_o <= wake_d;
         timer_wake_o <= {cfg.int_wake[`WSC_BIT_TMR_TWO],
            cfg.int_wake[`WSC_BIT_TMR_ONE]};
         meas_active_o <= meas_sel & cfg.normal_mode;
         can_wake_o <= can_d;
         pull_up_o <= {p3[0], p2[0], p1[0]};
         pull_down_o <= {p3[1], p2[1], p1[1]};
         pull_auto_o <= {p3[2], p2[2], p1[2]};
      end
   end

   property p_meas_mask;
      @(posedge core_clk_i) disable iff (sys_rst_i)
      meas_sel |=> (wake_en_o[1:0] == 2'h0);
   endproperty
   a_meas_mask: assert property (p_meas_mask) else $error("wake one/two not masked");
endmodule // wsc_wake_decode

// [design/wsc_int_gate.sv]
// Purpose: Gates wake and status events onto the interrupt request
// Assumes: Events are one-cycle pulses from the status logic
// Notes: Scope bit widens the request to all status events
`timescale 1ns/1ps
`include "wsc_defines.svh"
module wsc_int_gate
   import wsc_pkg::*;
(
   input wire logic core_clk_i, // 250 MHz clock
   input wire logic sys_rst_i, // Sync reset, high
   wsc_cfg_if.dst cfg, // Register images
   input wire logic wake_event_i, // Any wake event pulse
   input wire logic status_event_i, // Other status event pulse
   output logic int_req_o // Interrupt request pulse
);
   wire logic scope_all = cfg.ext_wake[`WSC_BIT_INT_SCOPE];
   wire logic req_d = wake_event_i | (scope_all & status_event_i);

   // One-cycle request, one clock behind the event
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         int_req_o <= 1'b0;
      end else begin
         int_req_o <= req_d;
      end
   end

   property p_scope_narrow;
      @(posedge core_clk_i) disable iff (sys_rst_i)
      (!scope_all && !wake_event_i) |=> !int_req_o;
   endproperty
   a_scope_narrow: assert property (p_scope_narrow) else $error("status leaked");
endmodule // wsc_int_gate

// [bench/wsc_host_model.sv]
// Purpose: Host microcontroller model on the register port
// Assumes: Strobes move 1 ns after a rising edge
// Notes: Released write data shows the inverse of its last value
`timescale 1ns/1ps
module wsc_host_model (
   input wire logic clk_i, // Core clock
   input wire logic [7:0] rdata_i, // Read data
   output logic wr_en_o, // Write strobe
   output logic rd_en_o, // Read strobe
   output logic [6:0] addr_o, // Register address
   output logic [7:0] wdata_o // Write data
);
   // Idle port at time zero
   initial {wr_en_o, rd_en_o, addr_o, wdata_o} = 17'h0_0000;
   // Strobe held over one edge; bus wake left to the transceiver code
   task automatic xfer(input logic w, input logic [6:0] a, input logic [7:0] d,
         output logic [7:0] q);
      @(posedge clk_i) #1 {wr_en_o, rd_en_o, addr_o, wdata_o} = {w, !w, a, d};
      @(posedge clk_i) #1 {wr_en_o, rd_en_o, wdata_o} = {2'b00, ~d};
      q = rdata_i; // Level status never used
   endtask
endmodule // wsc_host_model

// [bench/wsc_regs_bench.sv]
// Purpose: Self-checking bench of the wake bank
// Assumes: Inputs move 1 ns after the rising edge
// Notes: All eight transceiver codes are swept inside the peak-bit scenario
`timescale 1ns/1ps
module wsc_regs_bench;
   logic core_clk_i, sys_rst_i, hw_wd_val_i, wr_en_i, rd_en_i, rd_valid_o, access_err_o;
   logic peak_current_threshold_sel_o, watchdog_stop_disable_b1_o, int_scope_all_o;
   logic measure_mode_select_o, meas_active_o, can_wake_o, int_req_o;
   logic [1:0] mode_i, timer_wake_o;
   logic [2:0] can_mode_i, wake_en_o, pull_up_o, pull_down_o, pull_auto_o;
   logic [5:0] pul; // Soft, restart, fail-safe, watchdog, wake, status
   logic [6:0] addr_i;
   logic [7:0] wdata_i, rdata_o, q;
   int n_errors = 0, n_compared = 0, cyc = 0;
   wsc_regs dut (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .soft_rst_i(pul[0]),
      .restart_i(pul[1]), .failsafe_i(pul[2]), .mode_i(mode_i), .wr_en_i(wr_en_i),
      .rd_en_i(rd_en_i), .addr_i(addr_i), .wdata_i(wdata_i), .hw_wd_upd_i(pul[3]),
      .hw_wd_val_i(hw_wd_val_i), .can_mode_i(can_mode_i), .wake_event_i(pul[4]),
      .status_event_i(pul[5]), .rdata_o(rdata_o), .rd_valid_o(rd_valid_o),
      .access_err_o(access_err_o),
      .peak_current_threshold_sel_o(peak_current_threshold_sel_o),
      .watchdog_stop_disable_b1_o(watchdog_stop_disable_b1_o),
      .int_scope_all_o(int_scope_all_o), .measure_mode_select_o(measure_mode_select_o),
      .wake_en_o(wake_en_o), .timer_wake_o(timer_wake_o), .meas_active_o(meas_active_o),
      .can_wake_o(can_wake_o), .pull_up_o(pull_up_o), .pull_down_o(pull_down_o),
      .pull_auto_o(pull_auto_o), .int_req_o(int_req_o));
   wsc_host_model host (.clk_i(core_clk_i), .rdata_i(rdata_o), .wr_en_o(wr_en_i),
      .rd_en_o(rd_en_i), .addr_o(addr_i), .wdata_o(wdata_i));
   // Compare, register access and pulse helpers
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      host.xfer(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [6:0] a, input logic [7:0] x);
      host.xfer(1'b0, a, 8'h00, q);
      chk({rd_valid_o, q}, {1'b1, x});
   endtask
   task automatic rd4(input logic [31:0] x);
      for (int i = 0; i < 4; i++)
         rd(7'(5 + i), x[31 - 8 * i -: 8]);
   endtask
   task automatic pulse(input int b);
      @(posedge core_clk_i) #1 pul[b] = 1'b1;
      @(posedge core_clk_i) #1 pul[b] = 1'b0;
   endtask
   // Reset contents, all ones, then mixed codes and an unmapped read
   task automatic t_fields;
      rd4(32'h0000_0700);
      for (int a = 5; a < 9; a++)
         wr(7'(a), 8'hFF);
      rd4(32'h20C4_A73F);
      chk({peak_current_threshold_sel_o, timer_wake_o, watchdog_stop_disable_b1_o,
         int_scope_all_o, measure_mode_select_o, meas_active_o, wake_en_o, pull_up_o,
         pull_down_o, pull_auto_o}, 32'h0007_F807);
      wr(7'h06, 8'h40);
      wr(7'h07, 8'h03);
      wr(7'h08, 8'h24);
      rd(7'h09, 8'h00);
      chk({access_err_o, pull_up_o, pull_down_o, pull_auto_o, timer_wake_o, meas_active_o,
         wake_en_o}, 32'h0000_C413);
   endtask
   // Stop state locks the peak bit quietly; interrupt scope both ways
   task automatic t_stop_irq;
      mode_i = wsc_pkg::WSC_MODE_STOP;
      wr(7'h07, 8'h20);
      wr(7'h05, 8'h00);
      chk({access_err_o, int_req_o, meas_active_o}, 32'h0000_0000);
      rd(7'h05, 8'h20);
      pulse(5);
      chk(int_req_o, 32'h0000_0000);
      pulse(4);
      chk(int_req_o, 32'h0000_0001);
      wr(7'h07, 8'h83);
      pulse(5);
      chk(int_req_o, 32'h0000_0001);
   endtask
   // Watchdog bit set by hardware, then restart, fail-safe and soft reset
   task automatic t_loads;
      hw_wd_val_i = 1'b1;
      pulse(3);
      rd(7'h06, 8'h44);
      pulse(1);
      rd4(32'h2040_8324);
      wr(7'h07, 8'h20);
      pulse(2);
      rd(7'h07, 8'h27);
      rd(7'h05, 8'h00);
      pulse(0);
      rd4(32'h0000_0700);
      chk({peak_current_threshold_sel_o, timer_wake_o, watchdog_stop_disable_b1_o,
         int_scope_all_o, measure_mode_select_o, meas_active_o, wake_en_o, pull_up_o,
         pull_down_o, pull_auto_o}, 32'h0000_0E00);
   endtask
   // Peak bit per state, then every transceiver code as bus wake source
   task automatic t_peak_can;
      mode_i = wsc_pkg::WSC_MODE_INIT;
      wr(7'h05, 8'hFF);
      rd(7'h05, 8'h20);
      mode_i = wsc_pkg::WSC_MODE_OTHER;
      wr(7'h05, 8'h00);
      rd(7'h05, 8'h20);
      mode_i = wsc_pkg::WSC_MODE_NORMAL;
      wr(7'h05, 8'h00);
      rd(7'h05, 8'h00);
      chk(peak_current_threshold_sel_o, 32'h0000_0000);
      for (int m = 0; m < 8; m++) begin
         can_mode_i = 3'(m); // Bench drives each transceiver code
         @(posedge core_clk_i) #1 chk(can_wake_o, 32'(m == 1 || m == 5));
      end
   endtask
   // Counts, verdict, end of run
   task automatic summarize;
      $display("compared %0d, wrong %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // 250 MHz clock
   initial begin
      core_clk_i = 1'b0;
      forever #2 core_clk_i = ~core_clk_i;
   end
   // Reset held 12 cycles, then the scenarios
   initial begin
      {sys_rst_i, pul, hw_wd_val_i, can_mode_i, mode_i} = 13'h1001; // Reset on, normal
      repeat (12) @(posedge core_clk_i);
      #1 sys_rst_i = 1'b0;
      t_fields;
      t_stop_irq;
      t_loads;
      t_peak_can;
      summarize;
   end
   // Hang guard, far above the about 110 cycles needed
   always @(posedge core_clk_i)
      if (++cyc == 2000) begin
         n_errors++;
         summarize;
      end
endmodule // wsc_regs_bench
